/* File: pkg/dbg_defines.svh */
`ifndef DBG_DEFINES_SVH
`define DBG_DEFINES_SVH
// register offsets, low byte of the mapped address
`define OFF_CMD 8'h00
`define OFF_STAT 8'h01
`define OFF_SHIFT_HI 8'h02
`define OFF_SHIFT_LO 8'h03
`define OFF_ADDR_HI 8'h04
`define OFF_ADDR_LO 8'h05
`define OFF_FLAGS 8'h06
`define OFF_BCTL0 8'h20
`define OFF_BCTL1 8'h21
`define OFF_BAH 8'h22
`define OFF_BAL 8'h23
`define OFF_BCH 8'h24
`define OFF_BCL 8'h25
// command register fields
`define CMD_STEP_HI 4
`define CMD_STEP_LO 3
`define CMD_SEL_HI 2
`define CMD_SEL_LO 0
`define STEP_NONE 2'b00
`define STEP_GO 2'b01
`define STEP_TRACE 2'b10
`define STEP_TAG_RESUME 2'b11
`define SEL_NEXT 3'b010
`define SEL_PC 3'b011
// status fields
`define ST_PERMIT 7
`define ST_ACTIVE 6
`define ST_TAG 5
`define ST_SHIFT_VALID 4
`define ST_TRACE 3
// break control 0 fields
`define BC0_MODE_HI 7
`define BC0_MODE_LO 6
`define BC0_PM 5
`define BC0_R1 1
`define BC0_R0 0
// break control 1 fields
`define BC1_DBE 6
`define BC1_MBH 5
`define BC1_MBL 4
`define BC1_RWE1 3
`define BC1_RW1 2
`define BC1_RWE0 1
`define BC1_RW0 0
// break modes
`define MODE_OFF 2'b00
`define MODE_TRAP_DUAL 2'b01
`define MODE_FULL 2'b10
`define MODE_DBG_DUAL 2'b11
// reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`endif

/* File: pkg/dbg_pkg.sv */
package dbg_pkg;
   // run state of the debug logic
   typedef enum logic [1:0] {ST_RUN, ST_ROM_CHECK, ST_HALTED} dbg_state_t;
   // one observed cpu bus cycle
   typedef struct packed {
      logic valid;
      logic fetch;
      logic read;
      logic [15:0] addr;
      logic [15:0] data;
   } bus_cycle_t;
   // register access from the cpu bus while mapped
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
endpackage

/* File: rtl/debug_regs_bkpt.sv */
`timescale 1ns/100ps
// Function
// - step field 00 none, 01 resume, 10 single step, 11 tag and resume
// - select 010 is pre-increment-by-two access, 011 is program counter
// - permit clear refuses halted entry; hardware commands still run
// - active flag set exactly while halted and waiting for commands
// - tagging set by tag-resume, cleared on halt; blocks serial commands
// - shift valid flag shows shifter holds valid data
// - 16-bit shifter readable and writable in all modes
// - 16-bit address holder readable; only debug hardware loads it
// - condition flags saved on halt entry; firmware may rewrite copy
// - no breakpoint while halted or running debug firmware
// - mode bits select off, soft trap dual, full, halting dual
// - soft trap mode fetch only; range per point; direction, masks ignored
// - dual modes: second compare enable arms second address point
// - full mode: second range/direction ignored; data compare unless program-only
// - halting dual: program-only, range, direction qualify; masks ignored
// - breakpoints enter firmware even unpermitted; host sets permit first
// - program-only 0 breaks at boundary; 1 breaks on executed tagged opcode
// - first point compares low address byte only when its range bit set
// - dual second point compares low byte only when its range bit set
// - second compare disabled means compare registers unused
// - full mode masks exclude data bytes 15:8 and 7:0
// - dual second point direction compare applies only with second enable
// - second direction value 0 matches writes, 1 reads
// - first direction compare: 0 writes, 1 reads, disabled don't care
// - compare registers cleared only by power-on reset
`include "dbg_defines.svh"
module debug_regs_bkpt
(
   // clock and resets
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_por,
   // cpu register access
   input wire dbg_pkg::reg_req_t i_req,
   output logic [7:0] o_rdata,
   // serial hardware side
   input wire logic i_cmd_load,
   input wire logic [7:0] i_cmd_byte,
   input wire logic i_shift_load,
   input wire logic [15:0] i_shift_word,
   input wire logic i_shift_taken,
   input wire logic i_addr_load,
   input wire logic [15:0] i_addr_word,
   // core control side
   input wire logic i_halt_req,
   input wire logic i_cmd_exec,
   input wire logic i_rom_return,
   input wire logic i_tag_hit,
   input wire logic [7:0] i_flags,
   input wire dbg_pkg::bus_cycle_t i_bus,
   // core control outputs
   output logic o_debug_active,
   output logic o_rom_run,
   output logic o_serial_enable,
   output logic o_resume,
   output logic o_single_step,
   output logic o_sel_next,
   output logic o_sel_pc,
   output logic o_break_now,
   output logic o_fetch_tag,
   output logic o_soft_trap
);
   import dbg_pkg::*;

   dbg_state_t state;
   logic [7:0] cmd;
   logic permit;
   logic tagging_on;
   logic shift_valid;
   logic trace_flag;
   logic [15:0] shift_word;
   logic [15:0] addr_hold;
   logic [7:0] flags_copy;
   logic [7:0] bctl0;
   logic [7:0] bctl1;
   logic [7:0] bah;
   logic [7:0] bal;
   logic [7:0] bch;
   logic [7:0] bcl;
   logic tag_is_trap;
   logic [1:0] step;
   logic [1:0] mode;
   logic pm;
   logic dbe;
   logic exec_cmd;
   logic entering;
   logic bp_enter;
   logic hit0;
   logic hit1;
   logic any_hit;
   logic fetch_ok;

   // compare an address against a high/low pair, low byte optional
   function automatic logic addr_hit(input logic [15:0] a, input logic [7:0] hi,
                                     input logic [7:0] lo, input logic use_lo);
      addr_hit = (a[15:8] == hi) && (!use_lo || (a[7:0] == lo));
   endfunction

   // direction qualifier: value 0 write, 1 read
   function automatic logic dir_hit(input logic en, input logic val, input logic rd);
      dir_hit = !en || (val == rd);
   endfunction

   // field decode
   assign step = cmd[`CMD_STEP_HI:`CMD_STEP_LO];
   assign mode = bctl0[`BC0_MODE_HI:`BC0_MODE_LO];
   assign pm = bctl0[`BC0_PM];
   assign dbe = bctl1[`BC1_DBE];
   assign exec_cmd = i_cmd_exec && (state == ST_HALTED);
   assign entering = (state == ST_RUN) && (i_halt_req || bp_enter);

   // fetch qualification: trap mode and program-only restrict to fetches
   assign fetch_ok = i_bus.fetch || (!pm && (mode != `MODE_TRAP_DUAL));

   // comparator
   always_comb
   begin
      hit0 = 1'b0;
      hit1 = 1'b0;
      case (mode)
         `MODE_TRAP_DUAL:
         begin
            hit0 = addr_hit(i_bus.addr, bah, bal, bctl0[`BC0_R0]);
            hit1 = dbe && addr_hit(i_bus.addr, bch, bcl, bctl0[`BC0_R1]);
         end
         `MODE_FULL:
         begin
            hit0 = addr_hit(i_bus.addr, bah, bal, bctl0[`BC0_R0])
               && (pm || dir_hit(bctl1[`BC1_RWE0], bctl1[`BC1_RW0], i_bus.read))
               && (pm || !dbe || ((bctl1[`BC1_MBH] || i_bus.data[15:8] == bch)
               && (bctl1[`BC1_MBL] || i_bus.data[7:0] == bcl)));
         end
         `MODE_DBG_DUAL:
         begin
            hit0 = addr_hit(i_bus.addr, bah, bal, bctl0[`BC0_R0])
               && (pm || dir_hit(bctl1[`BC1_RWE0], bctl1[`BC1_RW0], i_bus.read));
            hit1 = dbe && addr_hit(i_bus.addr, bch, bcl, bctl0[`BC0_R1])
               && (pm || dir_hit(bctl1[`BC1_RWE1], bctl1[`BC1_RW1], i_bus.read));
         end
         default:
         begin
            hit0 = 1'b0;
            hit1 = 1'b0;
         end
      endcase
   end

   // suppressed outside the run state
   assign any_hit = (state == ST_RUN) && i_bus.valid && fetch_ok && (hit0 || hit1);

   // a debug-mode break enters now or once the tagged opcode executes
   assign bp_enter = (mode != `MODE_TRAP_DUAL) && (mode != `MODE_OFF)
      && ((any_hit && !pm) || (i_tag_hit && !tag_is_trap && pm));

   // run state machine
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         state <= ST_RUN;
      else
      begin
         case (state)
            ST_RUN:
            begin
               if (i_halt_req && permit)
                  state <= ST_HALTED;
               else if (bp_enter)
                  state <= permit ? ST_HALTED : ST_ROM_CHECK;
            end
            ST_ROM_CHECK:
            begin
               if (i_rom_return)
                  state <= ST_RUN;
            end
            ST_HALTED:
            begin
               if (exec_cmd && step != `STEP_NONE)
                  state <= ST_RUN;
            end
            default:
               state <= ST_RUN;
         endcase
      end
   end

   // command register
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         cmd <= `RST_BYTE;
      else if (i_cmd_load && !tagging_on)
         cmd <= i_cmd_byte;
      else if (i_req.wr && i_req.addr == `OFF_CMD)
         cmd <= i_req.wdata;
   end

   // status flags
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         permit <= 1'b0;
         tagging_on <= 1'b0;
         trace_flag <= 1'b0;
      end
      else
      begin
         if (i_req.wr && i_req.addr == `OFF_STAT)
            permit <= i_req.wdata[`ST_PERMIT];
         if (entering)
            tagging_on <= 1'b0;
         else if (exec_cmd && step == `STEP_TAG_RESUME)
            tagging_on <= 1'b1;
         if (entering)
            trace_flag <= 1'b0;
         else if (exec_cmd && step == `STEP_TRACE)
            trace_flag <= 1'b1;
      end
   end

   // shifter and its valid flag, set wins over clear
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         shift_word <= `RST_WORD;
         shift_valid <= 1'b0;
      end
      else
      begin
         if (i_shift_load)
            shift_word <= i_shift_word;
         else if (i_req.wr && i_req.addr == `OFF_SHIFT_HI)
            shift_word[15:8] <= i_req.wdata;
         else if (i_req.wr && i_req.addr == `OFF_SHIFT_LO)
            shift_word[7:0] <= i_req.wdata;
         if (i_shift_load)
            shift_valid <= 1'b1;
         else if (i_shift_taken)
            shift_valid <= 1'b0;
      end
   end

   // address holder, hardware load only
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         addr_hold <= `RST_WORD;
      else if (i_addr_load)
         addr_hold <= i_addr_word;
   end

   // saved condition flags
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         flags_copy <= `RST_BYTE;
      else if (entering)
         flags_copy <= i_flags;
      else if (i_req.wr && i_req.addr == `OFF_FLAGS)
         flags_copy <= i_req.wdata;
   end

   // break control registers
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         bctl0 <= `RST_BYTE;
         bctl1 <= `RST_BYTE;
      end
      else
      begin
         if (i_req.wr && i_req.addr == `OFF_BCTL0)
            bctl0 <= i_req.wdata;
         if (i_req.wr && i_req.addr == `OFF_BCTL1)
            bctl1 <= i_req.wdata;
      end
   end

   // compare registers, power-on reset only
   always_ff @(posedge i_sys_clk)
   begin
      if (i_por)
      begin
         bah <= `RST_BYTE;
         bal <= `RST_BYTE;
         bch <= `RST_BYTE;
         bcl <= `RST_BYTE;
      end
      else
      begin
         if (i_req.wr && i_req.addr == `OFF_BAH)
            bah <= i_req.wdata;
         if (i_req.wr && i_req.addr == `OFF_BAL)
            bal <= i_req.wdata;
         if (i_req.wr && i_req.addr == `OFF_BCH)
            bch <= i_req.wdata;
         if (i_req.wr && i_req.addr == `OFF_BCL)
            bcl <= i_req.wdata;
      end
   end

   // kind of pending tagged break
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         tag_is_trap <= 1'b0;
      else if (any_hit && (pm || mode == `MODE_TRAP_DUAL))
         tag_is_trap <= (mode == `MODE_TRAP_DUAL);
   end

   // register read data
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         o_rdata <= `RST_BYTE;
      else if (!i_req.rd)
         o_rdata <= `RST_BYTE;
      else if (i_req.addr == `OFF_CMD)
         o_rdata <= cmd;
      else if (i_req.addr == `OFF_STAT)
         o_rdata <= {permit, state == ST_HALTED, tagging_on, shift_valid, trace_flag, 3'b000};
      else if (i_req.addr == `OFF_SHIFT_HI)
         o_rdata <= shift_word[15:8];
      else if (i_req.addr == `OFF_SHIFT_LO)
         o_rdata <= shift_word[7:0];
      else if (i_req.addr == `OFF_ADDR_HI)
         o_rdata <= addr_hold[15:8];
      else if (i_req.addr == `OFF_ADDR_LO)
         o_rdata <= addr_hold[7:0];
      else if (i_req.addr == `OFF_FLAGS)
         o_rdata <= flags_copy;
      else if (i_req.addr == `OFF_BCTL0)
         o_rdata <= bctl0;
      else if (i_req.addr == `OFF_BCTL1)
         o_rdata <= bctl1;
      else if (i_req.addr == `OFF_BAH)
         o_rdata <= bah;
      else if (i_req.addr == `OFF_BAL)
         o_rdata <= bal;
      else if (i_req.addr == `OFF_BCH)
         o_rdata <= bch;
      else if (i_req.addr == `OFF_BCL)
         o_rdata <= bcl;
      else
         o_rdata <= `RST_BYTE;
   end

   // control outputs, one cycle after their cause
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_debug_active <= 1'b0;
         o_rom_run <= 1'b0;
         o_serial_enable <= 1'b0;
         o_resume <= 1'b0;
         o_single_step <= 1'b0;
         o_sel_next <= 1'b0;
         o_sel_pc <= 1'b0;
         o_break_now <= 1'b0;
         o_fetch_tag <= 1'b0;
         o_soft_trap <= 1'b0;
      end
      else
      begin
         o_debug_active <= (state == ST_HALTED);
         o_rom_run <= (state != ST_RUN);
         o_serial_enable <= !tagging_on;
         o_resume <= exec_cmd && (step == `STEP_GO || step == `STEP_TAG_RESUME);
         o_single_step <= exec_cmd && (step == `STEP_TRACE);
         o_sel_next <= exec_cmd && (cmd[`CMD_SEL_HI:`CMD_SEL_LO] == `SEL_NEXT);
         o_sel_pc <= exec_cmd && (cmd[`CMD_SEL_HI:`CMD_SEL_LO] == `SEL_PC);
         o_break_now <= entering && !i_halt_req;
         o_fetch_tag <= any_hit && (pm || mode == `MODE_TRAP_DUAL);
         o_soft_trap <= (state == ST_RUN) && i_tag_hit && tag_is_trap;
      end
   end

   // halt entry sequence
   sequence s_halt_entry;
      (state == ST_RUN) && i_halt_req && permit;
   endsequence

   property p_permit_entry;
      @(posedge i_sys_clk) disable iff (i_rst)
      s_halt_entry |=> (state == ST_HALTED) ##1 o_debug_active;
   endproperty
   a_permit_entry: assert property (p_permit_entry) else $error("permitted halt not entered");

   property p_refuse_entry;
      @(posedge i_sys_clk) disable iff (i_rst)
      (state == ST_RUN) && i_halt_req && !permit && !bp_enter |=> state == ST_RUN;
   endproperty
   a_refuse_entry: assert property (p_refuse_entry) else $error("halt entered without permit");

   property p_active_flag;
      @(posedge i_sys_clk) disable iff (i_rst)
      ##1 o_debug_active == ($past(state) == ST_HALTED);
   endproperty
   a_active_flag: assert property (p_active_flag) else $error("active flag wrong");

   property p_tag_clear;
      @(posedge i_sys_clk) disable iff (i_rst)
      entering |=> !tagging_on ##1 o_serial_enable;
   endproperty
   a_tag_clear: assert property (p_tag_clear) else $error("tagging survives halt");

   property p_go_resume;
      @(posedge i_sys_clk) disable iff (i_rst)
      exec_cmd && step == `STEP_GO |=> o_resume && !o_single_step && state == ST_RUN;
   endproperty
   a_go_resume: assert property (p_go_resume) else $error("resume not issued");

   property p_no_break_halted;
      @(posedge i_sys_clk) disable iff (i_rst)
      state != ST_RUN |=> !o_break_now && !o_fetch_tag;
   endproperty
   a_no_break_halted: assert property (p_no_break_halted) else $error("break while halted");

   property p_flags_saved;
      @(posedge i_sys_clk) disable iff (i_rst)
      entering |=> flags_copy == $past(i_flags);
   endproperty
   a_flags_saved: assert property (p_flags_saved) else $error("flags not saved");

   property p_mode_off;
      @(posedge i_sys_clk) disable iff (i_rst)
      mode == `MODE_OFF |=> !o_fetch_tag && !o_break_now;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("break with mode off");

   property p_addr_readonly;
      @(posedge i_sys_clk) disable iff (i_rst)
      !i_addr_load |=> addr_hold == $past(addr_hold);
   endproperty
   a_addr_readonly: assert property (p_addr_readonly) else $error("address holder changed");

   property p_sdv_set;
      @(posedge i_sys_clk) disable iff (i_rst)
      i_shift_load |=> shift_valid && shift_word == $past(i_shift_word);
   endproperty
   a_sdv_set: assert property (p_sdv_set) else $error("shift valid not set");
endmodule // debug_regs_bkpt

/* File: tb/debug_host.sv */
`timescale 1ns/100ps
module debug_host
(
   // clock
   input wire logic i_sys_clk,
   // serial hardware side of the block
   output logic o_cmd_load,
   output logic [7:0] o_cmd_byte,
   output logic o_shift_load,
   output logic [15:0] o_shift_word,
   output logic o_shift_taken,
   output logic o_addr_load,
   output logic [15:0] o_addr_word,
   output logic o_halt_req
);
   // idle lines at time zero
   initial
   begin
      o_cmd_load = 1'b0;
      o_cmd_byte = 8'h00;
      o_shift_load = 1'b0;
      o_shift_word = 16'h0000;
      o_shift_taken = 1'b0;
      o_addr_load = 1'b0;
      o_addr_word = 16'h0000;
      o_halt_req = 1'b0;
   end
   // one edge past the strobe, then 1 ns
   task automatic step2;
      @(posedge i_sys_clk);
      #1;
   endtask
   // command byte; released data shows its inverse
   task automatic send_cmd(input logic [7:0] b);
      o_cmd_byte = b;
      o_cmd_load = 1'b1;
      step2();
      o_cmd_load = 1'b0;
      o_cmd_byte = ~b;
      step2();
   endtask
   // shifter word from the link
   task automatic shift(input logic [15:0] w);
      o_shift_word = w;
      o_shift_load = 1'b1;
      step2();
      o_shift_load = 1'b0;
      o_shift_word = ~w;
      step2();
   endtask
   // firmware has consumed the shifter
   task automatic taken;
      o_shift_taken = 1'b1;
      step2();
      o_shift_taken = 1'b0;
      step2();
   endtask
   // hardware address load
   task automatic addr(input logic [15:0] w);
      o_addr_word = w;
      o_addr_load = 1'b1;
      step2();
      o_addr_load = 1'b0;
      o_addr_word = ~w;
      step2();
   endtask
   // background request
   task automatic halt;
      o_halt_req = 1'b1;
      step2();
      o_halt_req = 1'b0;
      step2();
   endtask
endmodule // debug_host

/* File: tb/tb.sv */
`timescale 1ns/100ps
`include "dbg_defines.svh"
module tb;
   import dbg_pkg::*;
   // stimulus and observed signals
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_por = 1'b1;
   reg_req_t req = '0;
   bus_cycle_t bus = '0;
   bus_cycle_t b;
   logic cmd_exec = 1'b0;
   logic rom_ret = 1'b0;
   logic tag_hit = 1'b0;
   logic permit = 1'b0;
   logic [7:0] flags = 8'h00;
   logic cmd_load, shift_load, shift_taken, addr_load, halt_req;
   logic [7:0] cmd_byte, rdata, v;
   logic [15:0] shift_word, addr_word;
   logic act, romr, ser_en, resume, sstep, snext, spc, brk, ftag, trap;
   logic [31:0] r, q;
   logic [1:0] steps [5] = '{2'b00, 2'b00, 2'b01, 2'b10, 2'b11};
   logic [2:0] sels [5] = '{3'b010, 3'b011, 3'b000, 3'b011, 3'b010};
   int err_count = 0;
   int checks = 0;
   int seed = 32'h70cc;
   // 125 MHz clock
   always #4 i_sys_clk = ~i_sys_clk;
   // far side and block
   debug_host host (.i_sys_clk(i_sys_clk), .o_cmd_load(cmd_load), .o_cmd_byte(cmd_byte),
      .o_shift_load(shift_load), .o_shift_word(shift_word), .o_shift_taken(shift_taken),
      .o_addr_load(addr_load), .o_addr_word(addr_word), .o_halt_req(halt_req));
   debug_regs_bkpt dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_por(i_por), .i_req(req),
      .o_rdata(rdata), .i_cmd_load(cmd_load), .i_cmd_byte(cmd_byte), .i_shift_load(shift_load),
      .i_shift_word(shift_word), .i_shift_taken(shift_taken), .i_addr_load(addr_load),
      .i_addr_word(addr_word), .i_halt_req(halt_req), .i_cmd_exec(cmd_exec), .i_rom_return(rom_ret),
      .i_tag_hit(tag_hit), .i_flags(flags), .i_bus(bus), .o_debug_active(act), .o_rom_run(romr),
      .o_serial_enable(ser_en), .o_resume(resume), .o_single_step(sstep), .o_sel_next(snext),
      .o_sel_pc(spc), .o_break_now(brk), .o_fetch_tag(ftag), .o_soft_trap(trap));
   // verdict and end of run
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
      begin
         $display("Regression OK");
      end
      else
      begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // compare helpers
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e)
      begin
         err_count++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic chk1(input string n, input logic s, input logic e);
      chk(n, {15'h0000, s}, {15'h0000, e});
   endtask
   task automatic tick;
      @(posedge i_sys_clk);
      #1;
   endtask
   // register bus cycles
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req = '{wr:1'b1, rd:1'b0, addr:a, wdata:d};
      tick();
      req = '0;
      tick();
   endtask
   task automatic rd(input logic [7:0] a);
      req = '{wr:1'b0, rd:1'b1, addr:a, wdata:8'h00};
      tick();
      req = '0;
      v = rdata;
      tick();
   endtask
   task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
      rd(a);
      chk(n, {8'h00, v}, {8'h00, e});
   endtask
   // load and execute one command while halted
   task automatic exec_cmd(input logic [1:0] st, input logic [2:0] sel);
      host.send_cmd({3'b000, st, sel});
      cmd_exec = 1'b1;
      tick();
      cmd_exec = 1'b0;
      chk1("resume", resume, st == `STEP_GO || st == `STEP_TAG_RESUME);
      chk1("step", sstep, st == `STEP_TRACE);
      chk1("next", snext, sel == `SEL_NEXT);
      chk1("pc", spc, sel == `SEL_PC);
      tick();
      chk1("act", act, st == `STEP_NONE);
   endtask
   // expected {break, tag} for one bus cycle
   function automatic logic [1:0] exp_hit(input logic [7:0] c0, c1, input logic [15:0] ba, bc,
      input bus_cycle_t x);
      logic pm, h0, h1, d0, d1, dm, hit;
      pm = c0[5] || c0[7:6] == `MODE_TRAP_DUAL;
      h0 = x.addr[15:8] == ba[15:8] && (!c0[0] || x.addr[7:0] == ba[7:0]);
      h1 = c1[6] && x.addr[15:8] == bc[15:8] && (!c0[1] || x.addr[7:0] == bc[7:0]);
      d0 = pm || !c1[1] || x.read == c1[0];
      d1 = pm || !c1[3] || x.read == c1[2];
      dm = pm || !c1[6] || ((c1[5] || x.data[15:8] == bc[15:8]) && (c1[4] || x.data[7:0] == bc[7:0]));
      if (c0[7:6] == `MODE_OFF || (pm && !x.fetch))
         hit = 1'b0;
      else if (c0[7:6] == `MODE_FULL)
         hit = h0 && d0 && dm;
      else
         hit = (h0 && d0) || (h1 && d1);
      return pm ? {1'b0, hit} : {hit, 1'b0};
   endfunction
   // set up breakpoint, run one bus cycle, recover from halt
   task automatic bp_try(input logic [7:0] c0, c1, input logic [15:0] ba, bc, input bus_cycle_t x);
      logic [1:0] e;
      wr(`OFF_BCTL0, c0);
      wr(`OFF_BCTL1, c1);
      wr(`OFF_BAH, ba[15:8]);
      wr(`OFF_BAL, ba[7:0]);
      wr(`OFF_BCH, bc[15:8]);
      wr(`OFF_BCL, bc[7:0]);
      e = exp_hit(c0, c1, ba, bc, x);
      bus = x;
      tick();
      bus = {1'b0, ~x[33:0]};
      chk1("break", brk, e[1]);
      chk1("ftag", ftag, e[0]);
      tick();
      chk1("act", act, e[1] & permit);
      if (act === 1'b1)
         exec_cmd(`STEP_GO, 3'b000);
   endtask
   // hang guard
   initial
   begin
      repeat (100000) @(posedge i_sys_clk);
      err_count++;
      report_and_stop();
   end
   // main sequence
   initial
   begin
      repeat (20) tick();
      i_rst = 1'b0;
      i_por = 1'b0;
      wr(`OFF_BAH, 8'h5a);
      wr(`OFF_BCL, 8'ha5);
      wr(`OFF_BCTL0, 8'h80);
      wr(`OFF_BCTL1, 8'h7f);
      i_rst = 1'b1;
      tick();
      i_rst = 1'b0;
      tick();
      rd_chk("bah", `OFF_BAH, 8'h5a);
      rd_chk("bcl", `OFF_BCL, 8'ha5);
      rd_chk("bctl0", `OFF_BCTL0, 8'h00);
      rd_chk("bctl1", `OFF_BCTL1, 8'h00);
      i_rst = 1'b1;
      i_por = 1'b1;
      tick();
      i_rst = 1'b0;
      i_por = 1'b0;
      tick();
      rd_chk("bah", `OFF_BAH, 8'h00);
      $display("test resets done");
      host.shift(16'hc3a5);
      rd(`OFF_STAT);
      chk1("shift_valid", v[`ST_SHIFT_VALID], 1'b1);
      rd_chk("shift_hi", `OFF_SHIFT_HI, 8'hc3);
      rd_chk("shift_lo", `OFF_SHIFT_LO, 8'ha5);
      host.taken();
      rd(`OFF_STAT);
      chk1("shift_valid", v[`ST_SHIFT_VALID], 1'b0);
      wr(`OFF_SHIFT_LO, 8'h3c);
      rd_chk("shift_lo", `OFF_SHIFT_LO, 8'h3c);
      host.addr(16'h1234);
      wr(`OFF_ADDR_HI, 8'hff);
      rd_chk("addr_hi", `OFF_ADDR_HI, 8'h12);
      rd_chk("addr_lo", `OFF_ADDR_LO, 8'h34);
      $display("test holding regs done");
      flags = 8'hd5;
      host.halt();
      chk1("act", act, 1'b0);
      wr(`OFF_STAT, 8'h80);
      permit = 1'b1;
      host.halt();
      chk1("act", act, 1'b1);
      rd_chk("saved_flags", `OFF_FLAGS, 8'hd5);
      wr(`OFF_FLAGS, 8'h0f);
      rd_chk("saved_flags", `OFF_FLAGS, 8'h0f);
      for (int i = 0; i < 5; i++)
      begin
         if (act !== 1'b1)
            host.halt();
         exec_cmd(steps[i], sels[i]);
      end
      rd(`OFF_STAT);
      chk1("tag", v[`ST_TAG], 1'b1);
      chk1("ser_en", ser_en, 1'b0);
      host.send_cmd(8'h08);
      rd_chk("cmd", `OFF_CMD, 8'h1a);
      host.halt();
      rd(`OFF_STAT);
      chk1("tag", v[`ST_TAG], 1'b0);
      chk1("ser_en", ser_en, 1'b1);
      $display("test commands done");
      wr(`OFF_BCTL0, 8'h81);
      wr(`OFF_BAH, 8'h12);
      wr(`OFF_BAL, 8'h34);
      bus = '{valid:1'b1, fetch:1'b0, read:1'b1, addr:16'h1234, data:16'h0000};
      tick();
      bus = '0;
      chk1("break", brk, 1'b0);
      tick();
      exec_cmd(`STEP_GO, 3'b000);
      wr(`OFF_STAT, 8'h00);
      permit = 1'b0;
      bp_try(8'h81, 8'h00, 16'h1234, 16'h0000, '{1'b1, 1'b0, 1'b0, 16'h1234, 16'h0000});
      chk1("rom_run", romr, 1'b1);
      rom_ret = 1'b1;
      tick();
      rom_ret = 1'b0;
      tick();
      chk1("rom_run", romr, 1'b0);
      wr(`OFF_STAT, 8'h80);
      permit = 1'b1;
      bp_try(8'h40, 8'h00, 16'h1200, 16'h0000, '{1'b1, 1'b1, 1'b1, 16'h12ee, 16'h0000});
      tag_hit = 1'b1;
      tick();
      tag_hit = 1'b0;
      chk1("trap", trap, 1'b1);
      tick();
      bp_try(8'ha0, 8'h00, 16'h1200, 16'h0000, '{1'b1, 1'b1, 1'b1, 16'h12ee, 16'h0000});
      tag_hit = 1'b1;
      tick();
      tag_hit = 1'b0;
      chk1("break", brk, 1'b1);
      chk1("trap", trap, 1'b0);
      tick();
      chk1("act", act, 1'b1);
      exec_cmd(`STEP_GO, 3'b000);
      $display("test breakpoint corners done");
      for (int i = 0; i < 60; i++)
      begin
         r = $random(seed);
         q = $random(seed);
         b = '{valid:1'b1, fetch:r[21], read:r[20], addr:(r[17] ? q[15:0] : q[31:16]), data:16'h0000};
         if (r[18])
            b.addr[7:0] = r[31:24];
         b.data = r[19] ? q[31:16] : {r[31:24], r[27:20]};
         bp_try({r[7:5], 3'b000, r[9:8]}, {1'b0, r[16:10]}, q[15:0], q[31:16], b);
      end
      $display("test random breakpoints done");
      report_and_stop();
   end
endmodule // tb
